// ==== oce_consts.vh ====
// Constants for the operation command executor
//
// Contract
// [RQ1] Two write modes, backup and RAM write, chosen by info; RAM write after reset.
// [RQ2] Backup mode commits every secondary-port setting write.
// [RQ3] RAM mode keeps run-changeable writes volatile; stop/reset-only writes still commit.
// [RQ4] Changing RAM mode to backup mode commits nothing by itself.
// [RQ5] Primary-port setting writes always commit, whatever the write mode.
// [RQ6] Software reset acts as power cycle; host issues it only with all stopped.
// [RQ7] Run and stop act only on the channels the info selects.
// [RQ8] Auto/manual on selected channels; auto-to-manual commits manipulated value.
// [RQ9] Manual cancels running tuning; asking for the current mode answers normal.
// [RQ10] Tuning execute/cancel refused when stopped, manual, on/off, or other variant runs.
// [RQ11] Bank change picks bank 0..3 on selected channels; refused while autotuning.
// [RQ12] Local/remote setpoint choice on selected channels; refused while autotuning.
// [RQ13] Error reset clears burnout, sensor, overcurrent latches, overcurrent and error-run.
// [RQ14] Alarm latch cancel clears selected latches only when latching is enabled.
// [RQ15] First save commits only the run-changeable parameters.
// [RQ16] Parameter initialisation restores defaults and commits nothing.
// [RQ17] Second save commits every writable setting; host issues it only when stopped.
// [RQ18] Configuration command registers or clears the power unit configuration.
// [RQ19] Overlong, short, and bad code or info each get their own answer code.
// [RQ20] Not accepting or nonvolatile busy gives its busy code; host retries.
// [RQ21] State errors: one code running, one stopped, one during reset or startup.
// [RQ22] Manual, tuning, control-mode refusals have own codes; success answers normal.
// [RQ23] Channel info is one channel or all channels; else parameter error.
`ifndef OCE_CONSTS_VH
`define OCE_CONSTS_VH

// Register byte offsets
`define OCE_ADDR_CMD    8'h00
`define OCE_ADDR_RESP   8'h04
`define OCE_ADDR_CHST   8'h08
`define OCE_ADDR_CFG    8'h0c
`define OCE_ADDR_LATCH  8'h10

// CMD field positions
`define OCE_CMD_PRIMARY 16
`define OCE_CMD_SHORT   17
`define OCE_CMD_LONG    18
// RESP done flag position
`define OCE_RESP_DONE   16

// Command codes
`define OCE_OP_WMODE    8'h04
`define OCE_OP_SRESET   8'h06
`define OCE_OP_RUN      8'h0a
`define OCE_OP_STOP     8'h0b
`define OCE_OP_MANUAL   8'h0c
`define OCE_OP_AUTO     8'h0d
`define OCE_OP_AT40     8'h0e
`define OCE_OP_AT100    8'h0f
`define OCE_OP_ATCAN    8'h10
`define OCE_OP_BANK0    8'h1e
`define OCE_OP_BANK3    8'h21
`define OCE_OP_LSP      8'h22
`define OCE_OP_RSP      8'h23
`define OCE_OP_ERRRST   8'h2d
`define OCE_OP_ALM1     8'h32
`define OCE_OP_ALM2     8'h33
`define OCE_OP_ALM3     8'h34
`define OCE_OP_ALMALL   8'h35
`define OCE_OP_SAVE     8'h37
`define OCE_OP_PINIT    8'h38
`define OCE_OP_SAVE2    8'h39
`define OCE_OP_UCFG     8'h3b

// Related information values
`define OCE_INFO_ZERO   8'h00
`define OCE_INFO_ONE    8'h01
`define OCE_INFO_ALL    8'hff

// Response codes, four decimal digits
`define OCE_RC_OK       16'h0000
`define OCE_RC_LONG     16'h1001
`define OCE_RC_SHORT    16'h1002
`define OCE_RC_PARAM    16'h1100
`define OCE_RC_RUNNING  16'h2201
`define OCE_RC_STOPPED  16'h2202
`define OCE_RC_NOACCEPT 16'h7013
`define OCE_RC_NVBUSY   16'h7014
`define OCE_RC_STARTUP  16'h7015
`define OCE_RC_CTLMODE  16'h7020
`define OCE_RC_MANUAL   16'h7041
`define OCE_RC_TUNING   16'h7042

// Commit kinds
`define OCE_NV_SETTING  2'h0
`define OCE_NV_MV       2'h1
`define OCE_NV_RUNPAR   2'h2
`define OCE_NV_ALL      2'h3

// Timing counts in clock cycles
`define OCE_STARTUP_CYC 16'h0020
`define OCE_NVBUSY_CYC  16'h0040

`endif

// ==== oce_executor.v ====
// Operation command executor with AHB-Lite register slave
//
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "oce_consts.vh"

module oce_executor #(
   parameter [15:0] STARTUP_CYC = `OCE_STARTUP_CYC,
   parameter [15:0] NVBUSY_CYC  = `OCE_NVBUSY_CYC
) (
   // Clock and reset
   input  wire        mclk_i,
   input  wire        rst_n_i,
   // AHB-Lite slave
   input  wire        hsel_i,
   input  wire [31:0] haddr_i,
   input  wire [1:0]  htrans_i,
   input  wire        hwrite_i,
   input  wire [2:0]  hsize_i,
   input  wire [31:0] hwdata_i,
   input  wire        hready_i,
   output wire [31:0] hrdata_o,
   output wire        hreadyout_o,
   output wire        hresp_o,
   // Control loop status
   input  wire [3:0]  st_run_i,
   input  wire [3:0]  at_done_i,
   input  wire        cmd_hold_i,
   // Latch events
   input  wire [4:0]  err_set_i,
   input  wire [11:0] alm_set_i,
   // Setting writes from the ports
   input  wire        set_wr_i,
   input  wire        set_primary_i,
   input  wire        set_runchg_i,
   // Channel state
   output wire [3:0]  chan_run_o,
   output wire [3:0]  chan_manual_o,
   output wire [3:0]  chan_at40_o,
   output wire [3:0]  chan_at100_o,
   output wire [3:0]  chan_rsp_o,
   output wire [7:0]  chan_bank_o,
   output wire        unit_cfg_o,
   // Events
   output reg  [3:0]  st_cancel_o,
   output reg         soft_reset_o,
   output reg         param_init_o,
   output reg         nv_commit_o,
   output reg  [1:0]  nv_kind_o,
   output wire        nv_busy_o
);

   // ----------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------
   reg        wr_pend_reg;
   reg [7:0]  wr_addr_reg;
   reg [31:0] rdata_reg;
   reg [31:0] rdata_next;

   reg [3:0]  run_reg;
   reg [3:0]  manual_reg;
   reg [3:0]  at40_reg;
   reg [3:0]  at100_reg;
   reg [3:0]  rsp_reg;
   reg [7:0]  bank_reg;
   reg        backup_reg;
   reg        ucfg_reg;
   reg [4:0]  cfg_reg;
   reg [4:0]  err_reg;
   reg [11:0] alm_reg;
   reg [18:0] cmd_reg;
   reg [15:0] resp_reg;
   reg        done_reg;
   reg [15:0] start_cnt_reg;
   reg [15:0] nv_cnt_reg;

   wire addr_ok = hsel_i & htrans_i[1] & hready_i;
   wire rd_go   = addr_ok & ~hwrite_i;
   wire cmd_go  = wr_pend_reg & (wr_addr_reg == `OCE_ADDR_CMD);
   wire cfg_go  = wr_pend_reg & (wr_addr_reg == `OCE_ADDR_CFG);
   wire rd_resp = (haddr_i[7:0] == `OCE_ADDR_RESP);

   // Zero-wait slave: read data caught in address phase
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = rdata_reg;

   always @*
   begin
      case (haddr_i[7:0])
         `OCE_ADDR_CMD:   rdata_next = {13'h0, cmd_reg};
         `OCE_ADDR_RESP:  rdata_next = {15'h0, done_reg, resp_reg};
         `OCE_ADDR_CHST:  rdata_next = {start_cnt_reg != 16'h0000,
                                        nv_cnt_reg != 16'h0000,
                                        ucfg_reg, backup_reg, bank_reg,
                                        rsp_reg, at100_reg, at40_reg,
                                        manual_reg, run_reg};
         `OCE_ADDR_CFG:   rdata_next = {27'h0, cfg_reg};
         `OCE_ADDR_LATCH: rdata_next = {12'h000, alm_reg, 3'h0, err_reg};
         default:         rdata_next = 32'h00000000;
      endcase
   end

   always @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         rdata_reg   <= 32'h00000000;
      end
      else
      begin
         wr_pend_reg <= addr_ok & hwrite_i;
         if (addr_ok)
            wr_addr_reg <= haddr_i[7:0];
         if (rd_go)
            rdata_reg <= rdata_next;
      end
   end

   // ----------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------
   wire [7:0] op   = hwdata_i[15:8];
   wire [7:0] info = hwdata_i[7:0];
   wire [3:0] onoff    = cfg_reg[3:0];
   wire       alm_en   = cfg_reg[4];
   wire       any_run  = |run_reg;
   wire       starting = (start_cnt_reg != 16'h0000);
   wire       nv_busy  = (nv_cnt_reg != 16'h0000);
   wire [3:0] at_any   = at40_reg | at100_reg;

   reg        sel_ok;
   reg [3:0]  mask;
   reg [15:0] rc;

   always @*
   begin
      sel_ok = (info == `OCE_INFO_ALL) || (info[7:2] == 6'h00); // RQ23
      if (info == `OCE_INFO_ALL)
         mask = 4'hf;
      else
         mask = 4'h1 << info[1:0];
      if (starting)
         rc = `OCE_RC_STARTUP; // RQ21
      else if (nv_busy)
         rc = `OCE_RC_NVBUSY; // RQ20
      else if (cmd_hold_i)
         rc = `OCE_RC_NOACCEPT; // RQ20
      else if (hwdata_i[`OCE_CMD_LONG])
         rc = `OCE_RC_LONG; // RQ19
      else if (hwdata_i[`OCE_CMD_SHORT])
         rc = `OCE_RC_SHORT; // RQ19
      else
      begin
         rc = `OCE_RC_OK; // RQ22
         case (op)
            `OCE_OP_WMODE, `OCE_OP_UCFG:
               if (info[7:1] != 7'h00)
                  rc = `OCE_RC_PARAM; // RQ19
               else if (op == `OCE_OP_UCFG && any_run)
                  rc = `OCE_RC_RUNNING;
            `OCE_OP_SRESET:
               if (info != `OCE_INFO_ZERO)
                  rc = `OCE_RC_PARAM;
               else if (any_run)
                  rc = `OCE_RC_RUNNING; // RQ6 RQ21
            `OCE_OP_RUN, `OCE_OP_STOP,
            `OCE_OP_ALM1, `OCE_OP_ALM2, `OCE_OP_ALM3, `OCE_OP_ALMALL:
               if (!sel_ok)
                  rc = `OCE_RC_PARAM;
            `OCE_OP_MANUAL, `OCE_OP_AUTO:
               if (!sel_ok)
                  rc = `OCE_RC_PARAM;
               else if (|(mask & onoff))
                  rc = `OCE_RC_CTLMODE; // RQ22
            `OCE_OP_AT40, `OCE_OP_AT100, `OCE_OP_ATCAN:
               if (!sel_ok)
                  rc = `OCE_RC_PARAM;
               else if (|(mask & ~run_reg))
                  rc = `OCE_RC_STOPPED; // RQ10 RQ21
               else if (|(mask & manual_reg))
                  rc = `OCE_RC_MANUAL; // RQ10 RQ22
               else if (|(mask & onoff))
                  rc = `OCE_RC_CTLMODE; // RQ10
               else if (|(mask & st_run_i))
                  rc = `OCE_RC_TUNING; // RQ10
               else if (op == `OCE_OP_AT40 && |(mask & at100_reg))
                  rc = `OCE_RC_TUNING; // RQ10
               else if (op == `OCE_OP_AT100 && |(mask & at40_reg))
                  rc = `OCE_RC_TUNING; // RQ10
            8'h1e, 8'h1f, 8'h20, 8'h21, `OCE_OP_LSP, `OCE_OP_RSP:
               if (!sel_ok)
                  rc = `OCE_RC_PARAM;
               else if (|(mask & at_any))
                  rc = `OCE_RC_TUNING; // RQ11 RQ12
            `OCE_OP_ERRRST, `OCE_OP_PINIT:
               if (info != `OCE_INFO_ZERO)
                  rc = `OCE_RC_PARAM;
            `OCE_OP_SAVE, `OCE_OP_SAVE2:
               if (info != `OCE_INFO_ALL)
                  rc = `OCE_RC_PARAM;
               else if (op == `OCE_OP_SAVE2 && any_run)
                  rc = `OCE_RC_RUNNING; // RQ17
            default:
               rc = `OCE_RC_PARAM; // RQ19
         endcase
      end
   end

   wire exec = cmd_go & (rc == `OCE_RC_OK);

   // Latch clears; an event in the same cycle still sets its bit
   wire        srst_go = exec & (op == `OCE_OP_SRESET);
   wire        err_clr = srst_go | exec & (op == `OCE_OP_ERRRST); // RQ13
   wire [3:0]  alm_ch  = exec & alm_en ? mask : 4'h0; // RQ14
   wire [11:0] alm_clr = {12{srst_go}} |
      {alm_ch & {4{op == `OCE_OP_ALM3 || op == `OCE_OP_ALMALL}},
       alm_ch & {4{op == `OCE_OP_ALM2 || op == `OCE_OP_ALMALL}},
       alm_ch & {4{op == `OCE_OP_ALM1 || op == `OCE_OP_ALMALL}}};

   // Commit unless RAM mode holds a secondary-port run-changeable write
   wire set_commit = set_wr_i & (set_primary_i | backup_reg |
                                 ~set_runchg_i); // RQ2 RQ3 RQ5

   // ----------------------------------------------------------
   // State and effects
   // ----------------------------------------------------------
   integer i;

   always @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         run_reg       <= 4'h0;
         manual_reg    <= 4'h0;
         at40_reg      <= 4'h0;
         at100_reg     <= 4'h0;
         rsp_reg       <= 4'h0;
         bank_reg      <= 8'h00;
         backup_reg    <= 1'b0; // RQ1
         ucfg_reg      <= 1'b0;
         cfg_reg       <= 5'h00;
         err_reg       <= 5'h00;
         alm_reg       <= 12'h000;
         cmd_reg       <= 19'h00000;
         resp_reg      <= `OCE_RC_OK;
         done_reg      <= 1'b0;
         start_cnt_reg <= STARTUP_CYC;
         nv_cnt_reg    <= 16'h0000;
         st_cancel_o   <= 4'h0;
         soft_reset_o  <= 1'b0;
         param_init_o  <= 1'b0;
         nv_commit_o   <= 1'b0;
         nv_kind_o     <= `OCE_NV_SETTING;
      end
      else
      begin
         st_cancel_o  <= 4'h0;
         soft_reset_o <= 1'b0;
         param_init_o <= 1'b0;
         nv_commit_o  <= 1'b0;
         if (start_cnt_reg != 16'h0000)
            start_cnt_reg <= start_cnt_reg - 16'h0001;
         if (nv_cnt_reg != 16'h0000)
            nv_cnt_reg <= nv_cnt_reg - 16'h0001;
         if (cfg_go)
            cfg_reg <= hwdata_i[4:0];
         // Finished tuning drops its flag
         at40_reg  <= at40_reg & ~at_done_i;
         at100_reg <= at100_reg & ~at_done_i;
         if (set_commit)
         begin
            nv_commit_o <= 1'b1;
            nv_kind_o   <= `OCE_NV_SETTING;
            nv_cnt_reg  <= NVBUSY_CYC;
         end
         // A new response wins over the read clear
         if (rd_go && rd_resp)
            done_reg <= 1'b0;
         if (cmd_go)
         begin
            cmd_reg  <= hwdata_i[18:0];
            resp_reg <= rc;
            done_reg <= 1'b1;
         end
         if (exec)
         begin
            case (op)
               `OCE_OP_WMODE:
                  backup_reg <= ~info[0]; // RQ1 RQ4
               `OCE_OP_SRESET:
               begin
                  // Volatile state back to reset
                  soft_reset_o  <= 1'b1; // RQ6
                  run_reg       <= 4'h0;
                  manual_reg    <= 4'h0;
                  at40_reg      <= 4'h0;
                  at100_reg     <= 4'h0;
                  rsp_reg       <= 4'h0;
                  bank_reg      <= 8'h00;
                  backup_reg    <= 1'b0;
                  start_cnt_reg <= STARTUP_CYC;
               end
               `OCE_OP_RUN:
                  run_reg <= run_reg | mask; // RQ7
               `OCE_OP_STOP:
               begin
                  run_reg   <= run_reg & ~mask; // RQ7
                  at40_reg  <= at40_reg & ~mask & ~at_done_i;
                  at100_reg <= at100_reg & ~mask & ~at_done_i;
               end
               `OCE_OP_MANUAL:
               begin
                  manual_reg  <= manual_reg | mask; // RQ8
                  at40_reg    <= at40_reg & ~mask & ~at_done_i; // RQ9
                  at100_reg   <= at100_reg & ~mask & ~at_done_i;
                  st_cancel_o <= mask & st_run_i; // RQ9
                  if (|(mask & ~manual_reg))
                  begin
                     nv_commit_o <= 1'b1; // RQ8
                     nv_kind_o   <= `OCE_NV_MV;
                     nv_cnt_reg  <= NVBUSY_CYC;
                  end
               end
               `OCE_OP_AUTO:
                  manual_reg <= manual_reg & ~mask; // RQ8
               `OCE_OP_AT40:
                  at40_reg <= (at40_reg | mask) & ~at_done_i;
               `OCE_OP_AT100:
                  at100_reg <= (at100_reg | mask) & ~at_done_i;
               `OCE_OP_ATCAN:
               begin
                  at40_reg  <= at40_reg & ~mask & ~at_done_i;
                  at100_reg <= at100_reg & ~mask & ~at_done_i;
               end
               `OCE_OP_LSP:
                  rsp_reg <= rsp_reg & ~mask; // RQ12
               `OCE_OP_RSP:
                  rsp_reg <= rsp_reg | mask; // RQ12
               `OCE_OP_ERRRST, `OCE_OP_ALM1, `OCE_OP_ALM2, `OCE_OP_ALM3,
               `OCE_OP_ALMALL:
                  ; // Latch clears are applied below
               `OCE_OP_SAVE, `OCE_OP_SAVE2:
               begin
                  nv_commit_o <= 1'b1;
                  nv_kind_o   <= (op == `OCE_OP_SAVE) ? `OCE_NV_RUNPAR
                                                      : `OCE_NV_ALL; // RQ15 RQ17
                  nv_cnt_reg  <= NVBUSY_CYC;
               end
               `OCE_OP_PINIT:
               begin
                  // Defaults only; nothing is committed
                  param_init_o <= 1'b1; // RQ16
                  rsp_reg      <= 4'h0;
                  bank_reg     <= 8'h00;
                  cfg_reg      <= 5'h00;
               end
               `OCE_OP_UCFG:
                  ucfg_reg <= info[0]; // RQ18
               default:
                  for (i = 0; i < 4; i = i + 1)
                     if (mask[i])
                        bank_reg[2*i +: 2] <= op[1:0] - 2'h2; // RQ11
            endcase
         end
         err_reg <= (err_clr ? 5'h00 : err_reg) | err_set_i; // RQ13
         alm_reg <= (alm_reg & ~alm_clr) | alm_set_i; // RQ14
      end
   end

   assign chan_run_o    = run_reg;
   assign chan_manual_o = manual_reg;
   assign chan_at40_o   = at40_reg;
   assign chan_at100_o  = at100_reg;
   assign chan_rsp_o    = rsp_reg;
   assign chan_bank_o   = bank_reg;
   assign unit_cfg_o    = ucfg_reg;
   assign nv_busy_o     = nv_busy;

endmodule
`default_nettype wire

// ==== oce_host_model.sv ====
// Host-side AHB-Lite master model issuing single word transfers
`timescale 1ns/1ps
`default_nettype none
module oce_host_model (
   // Clock and slave answer
   input  wire logic        mclk_i,
   input  wire logic        hready_i,
   input  wire logic [31:0] hrdata_i,
   // Bus request
   output var  logic        hsel_o,
   output var  logic [31:0] haddr_o,
   output var  logic [1:0]  htrans_o,
   output var  logic        hwrite_o,
   output var  logic [2:0]  hsize_o,
   output var  logic [31:0] hwdata_o
);
   initial
   begin
      {hsel_o, haddr_o, htrans_o, hwrite_o, hwdata_o} = '0;
      hsize_o = 3'b010;
   end

   // Call right after a rising edge
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
             output logic [31:0] r);
      begin
         hsel_o <= 1'b1;
         haddr_o <= a;
         hwrite_o <= w;
         htrans_o <= 2'b10;
         @(posedge mclk_i);
         while (!hready_i)
            @(posedge mclk_i);
         hsel_o <= 1'b0;
         htrans_o <= 2'b00;
         hwdata_o <= w ? d : ~hwdata_o;
         @(posedge mclk_i);
         while (!hready_i)
            @(posedge mclk_i);
         r = hrdata_i;
      end
   endtask
endmodule
`default_nettype wire

// ==== oce_executor_props.sv ====
// Concurrent checks on the command executor ports
`timescale 1ns/1ps
`default_nettype none
module oce_executor_props #(
   parameter logic [15:0] NVBUSY_CYC = 16'h0040
) (
   // Clock and reset
   input wire logic       mclk_i,
   input wire logic       rst_n_i,
   // Setting writes
   input wire logic       set_wr_i,
   input wire logic       set_primary_i,
   input wire logic       set_runchg_i,
   // State and events
   input wire logic [3:0] chan_manual_o,
   input wire logic [3:0] chan_at40_o,
   input wire logic [3:0] chan_at100_o,
   input wire logic [7:0] chan_bank_o,
   input wire logic [3:0] st_cancel_o,
   input wire logic       soft_reset_o,
   input wire logic       param_init_o,
   input wire logic       nv_commit_o,
   input wire logic [1:0] nv_kind_o,
   input wire logic       nv_busy_o
);
   logic [15:0] busy_len_reg;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   // Busy stretch length
   always_ff @(posedge mclk_i or negedge rst_n_i)
      if (!rst_n_i)
         busy_len_reg <= 16'h0000;
      else if (nv_busy_o)
         busy_len_reg <= busy_len_reg + 16'h0001;
      else
         busy_len_reg <= 16'h0000;

   a_reset_clears: assert property (soft_reset_o |->
      chan_manual_o == 4'h0 && chan_bank_o == 8'h00 ##1 !soft_reset_o)
      else $error("soft reset left state or pulse");
   a_commit_busy: assert property (nv_commit_o |=> nv_busy_o)
      else $error("commit without busy");
   a_busy_length: assert property ($fell(nv_busy_o) |->
      busy_len_reg == NVBUSY_CYC)
      else $error("busy stretch length wrong");
   a_cancel_manual: assert property (st_cancel_o != 4'h0 |->
      (st_cancel_o & ~chan_manual_o) == 4'h0)
      else $error("tuning cancel without manual");
   a_tune_exclusive: assert property (
      (chan_at40_o & chan_at100_o) == 4'h0)
      else $error("both tuning variants on");
   a_init_nocommit: assert property (param_init_o |->
      !nv_commit_o && chan_bank_o == 8'h00 ##1 !nv_commit_o)
      else $error("init committed or kept banks");
   a_manual_commit: assert property (
      (chan_manual_o & ~$past(chan_manual_o)) != 4'h0 |->
      nv_commit_o && nv_kind_o == 2'h1)
      else $error("manual entry without value commit");
   a_primary_commit: assert property (
      set_wr_i && set_primary_i |=> nv_commit_o && nv_kind_o == 2'h0)
      else $error("primary write not committed");
   a_stoponly_commit: assert property (
      set_wr_i && !set_primary_i && !set_runchg_i |=> nv_commit_o)
      else $error("stop-only write not committed");

   c_soft_reset: cover property (soft_reset_o);
   c_cancel: cover property (st_cancel_o != 4'h0);
   c_init: cover property (param_init_o);
   c_save_all: cover property (nv_commit_o && nv_kind_o == 2'h3);
endmodule

bind oce_executor oce_executor_props #(.NVBUSY_CYC(NVBUSY_CYC)) u_props (
   .mclk_i, .rst_n_i, .set_wr_i, .set_primary_i, .set_runchg_i,
   .chan_manual_o, .chan_at40_o, .chan_at100_o, .chan_bank_o,
   .st_cancel_o, .soft_reset_o, .param_init_o, .nv_commit_o,
   .nv_kind_o, .nv_busy_o);
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the operation command executor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        mclk_i;
   logic        rst_n_i;
   logic        hsel_i;
   logic [31:0] haddr_i;
   logic [1:0]  htrans_i;
   logic        hwrite_i;
   logic [2:0]  hsize_i;
   logic [31:0] hwdata_i;
   wire  [31:0] hrdata_o;
   wire         hreadyout_o;
   logic [3:0]  st_run_i;
   logic        cmd_hold_i;
   logic [4:0]  err_set_i;
   logic [11:0] alm_set_i;
   logic        set_wr_i;
   logic        set_primary_i;
   logic        set_runchg_i;
   wire         unit_cfg_o;
   wire         nv_commit_o;
   wire  [1:0]  nv_kind_o;
   logic [31:0] r;
   logic [2:0]  fl;
   logic [3:0]  exp_run;
   logic [1:0]  kind;
   logic [11:0] a;
   integer      seed;
   integer      i;
   integer      mismatches;
   integer      total_checks;

   oce_executor #(.STARTUP_CYC(16'h0008), .NVBUSY_CYC(16'h0008)) uut (
      .mclk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
      .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
      .hreadyout_o, .hresp_o(), .st_run_i, .at_done_i(4'h0),
      .cmd_hold_i, .err_set_i, .alm_set_i, .set_wr_i, .set_primary_i,
      .set_runchg_i, .chan_run_o(), .chan_manual_o(), .chan_at40_o(),
      .chan_at100_o(), .chan_rsp_o(), .chan_bank_o(), .unit_cfg_o,
      .st_cancel_o(), .soft_reset_o(), .param_init_o(), .nv_commit_o,
      .nv_kind_o, .nv_busy_o());

   oce_host_model host (
      .mclk_i, .hready_i(hreadyout_o), .hrdata_i(hrdata_o),
      .hsel_o(hsel_i), .haddr_o(haddr_i), .htrans_o(htrans_i),
      .hwrite_o(hwrite_i), .hsize_o(hsize_i), .hwdata_o(hwdata_i));

   initial
   begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end

   always @(posedge mclk_i)
      if (nv_commit_o)
         kind <= nv_kind_o;

   function logic [3:0] sel(input logic [7:0] inf);
      sel = inf == 8'hff ? 4'hf : 4'h1 << inf[1:0];
   endfunction

   task finish_test;
      begin
         if (mismatches == 0 && total_checks > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask

   task cv(input logic [31:0] g, input logic [31:0] e);
      begin
         total_checks++;
         if (g !== e)
         begin
            mismatches++;
            $display("wrong value at %0t: %h not %h", $time, g, e);
         end
      end
   endtask

   task cr(input logic [16:0] g, input logic [15:0] e);
      begin
         total_checks++;
         if (g !== {1'b1, e})
         begin
            mismatches++;
            $display("wrong value at %0t: code %h not %h", $time, g, e);
         end
      end
   endtask

   task rd(input logic [7:0] ad);
      host.xfer(1'b0, {24'h0, ad}, 32'h0, r);
   endtask

   // Nonvolatile busy answers are retried, up to 40 tries, unless wanted
   task c(input logic [7:0] op, input logic [7:0] inf, input logic [15:0] e);
      integer n;
      begin
         n = 0;
         do
         begin
            host.xfer(1'b1, 32'h0, {13'h0, fl, op, inf}, r);
            rd(8'h04);
            n++;
         end while (r[15:0] == 16'h7014 && e != 16'h7014 && n < 40);
         cr(r[16:0], e);
      end
   endtask

   task setw(input logic p, input logic q);
      begin
         set_primary_i <= p;
         set_runchg_i <= q;
         set_wr_i <= 1'b1;
         @(posedge mclk_i);
         set_wr_i <= 1'b0;
         @(posedge mclk_i);
         rd(8'h08);
      end
   endtask

   initial
   begin
      repeat (20000) @(posedge mclk_i);
      mismatches++;
      finish_test;
   end

   initial
   begin
      {st_run_i, cmd_hold_i, err_set_i, alm_set_i} = 22'h0;
      {set_wr_i, set_primary_i, set_runchg_i, fl} = 6'h0;
      {exp_run, mismatches, total_checks, rst_n_i} = 0;
      seed = 40539;
      repeat (2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      rd(8'h08);
      cv(r[28], 1'b0);
      c(8'h0a, 8'h00, 16'h7015);
      repeat (10) @(posedge mclk_i);
      cmd_hold_i <= 1'b1;
      c(8'h0a, 8'h00, 16'h7013);
      cmd_hold_i <= 1'b0;
      fl = 3'h4;
      c(8'h0a, 8'h00, 16'h1001);
      fl = 3'h2;
      c(8'h0a, 8'h00, 16'h1002);
      fl = 3'h0;
      c(8'h0a, 8'h07, 16'h1100);
      c(8'h01, 8'h00, 16'h1100);
      for (i = 0; i < 12; i++)
      begin
         a = $random(seed);
         c(a[0] ? 8'h0a : 8'h0b, a[3] ? 8'hff : {6'h0, a[2:1]}, 16'h0);
         exp_run = a[0] ? exp_run | sel({8{a[3]}} | a[2:1])
                        : exp_run & ~sel({8{a[3]}} | a[2:1]);
         rd(8'h08);
         cv(r[3:0], exp_run);
      end
      c(8'h0a, 8'hff, 16'h0);
      c(8'h06, 8'h00, 16'h2201);
      c(8'h39, 8'hff, 16'h2201);
      c(8'h0b, 8'hff, 16'h0);
      c(8'h0e, 8'h00, 16'h2202);
      c(8'h0a, 8'h00, 16'h0);
      c(8'h0e, 8'h00, 16'h0);
      c(8'h0f, 8'h00, 16'h7042);
      c(8'h1f, 8'h00, 16'h7042);
      c(8'h23, 8'h00, 16'h7042);
      c(8'h0c, 8'h00, 16'h0);
      c(8'h0c, 8'h00, 16'h7014);
      c(8'h0c, 8'h00, 16'h0);
      rd(8'h08);
      cv(r[11:4], 8'h01);
      c(8'h0e, 8'h00, 16'h7041);
      c(8'h0d, 8'h00, 16'h0);
      c(8'h0a, 8'h01, 16'h0);
      st_run_i <= 4'h2;
      c(8'h0e, 8'h01, 16'h7042);
      c(8'h0c, 8'h01, 16'h0);
      st_run_i <= 4'h0;
      host.xfer(1'b1, 32'h0c, 32'h4, r);
      c(8'h0a, 8'h02, 16'h0);
      c(8'h0e, 8'h02, 16'h7020);
      c(8'h0c, 8'h02, 16'h7020);
      for (i = 0; i < 4; i++)
      begin
         c(8'h1e + i[7:0], 8'h03, 16'h0);
         rd(8'h08);
         cv(r[27:26], i[1:0]);
      end
      c(8'h23, 8'h03, 16'h0);
      rd(8'h08);
      cv(r[19:16], 4'h8);
      c(8'h22, 8'h03, 16'h0);
      rd(8'h08);
      cv(r[19:16], 4'h0);
      a = $random(seed);
      err_set_i <= 5'h1f;
      alm_set_i <= a;
      @(posedge mclk_i);
      err_set_i <= 5'h00;
      alm_set_i <= 12'h0;
      c(8'h2d, 8'h00, 16'h0);
      c(8'h32, 8'h00, 16'h0);
      rd(8'h10);
      cv(r[19:0], {a, 8'h00});
      host.xfer(1'b1, 32'h0c, 32'h14, r);
      c(8'h32, 8'h00, 16'h0);
      c(8'h33, 8'h01, 16'h0);
      rd(8'h10);
      cv(r[19:8], a & 12'hfde);
      c(8'h35, 8'hff, 16'h0);
      rd(8'h10);
      cv(r[19:8], 12'h0);
      repeat (10) @(posedge mclk_i);
      c(8'h04, 8'h00, 16'h0);
      rd(8'h08);
      cv(r[30:28], 3'h1);
      setw(1'b0, 1'b1);
      cv(r[30], 1'b1);
      repeat (10) @(posedge mclk_i);
      c(8'h04, 8'h01, 16'h0);
      setw(1'b0, 1'b1);
      cv(r[30:28], 3'h0);
      setw(1'b1, 1'b1);
      cv(r[30], 1'b1);
      repeat (10) @(posedge mclk_i);
      setw(1'b0, 1'b0);
      cv(r[30], 1'b1);
      c(8'h37, 8'hff, 16'h0);
      cv(kind, 2'h2);
      c(8'h0b, 8'hff, 16'h0);
      c(8'h39, 8'hff, 16'h0);
      cv(kind, 2'h3);
      c(8'h38, 8'h00, 16'h0);
      rd(8'h08);
      cv(r[27:20], 8'h00);
      c(8'h3b, 8'h01, 16'h0);
      cv(unit_cfg_o, 1'b1);
      c(8'h3b, 8'h00, 16'h0);
      cv(unit_cfg_o, 1'b0);
      c(8'h06, 8'h00, 16'h0);
      c(8'h0a, 8'h00, 16'h7015);
      finish_test;
   end
endmodule
`default_nettype wire
